// [pkg/acr_regs.svh]
// register offsets, field positions, reset values of the converter control and result block
// assumes byte addresses of the device's management bus register space
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH

`define ACR_OFS_CMP_CHAN_SEL   8'h41
`define ACR_OFS_VBAT_HIGH      8'h42
`define ACR_OFS_VBAT_LOW       8'h43
`define ACR_OFS_THERM_HIGH     8'h44
`define ACR_OFS_THERM_LOW      8'h45
`define ACR_OFS_ICHG_HIGH      8'h46
`define ACR_OFS_ICHG_LOW       8'h47
`define ACR_OFS_AUX_HIGH       8'h48

`define ACR_RST_CMP_CHAN_SEL   8'h40
`define ACR_CMP2_MSB           7
`define ACR_CMP2_LSB           5
`define ACR_CMP3_MSB           4
`define ACR_CMP3_LSB           2
`define ACR_RSVD_MSB           1
`define ACR_RSVD_LSB           0

`define ACR_UNMAPPED_READ      8'h00

`endif

// [pkg/acr_pkg.sv]
// types shared by the converter control and result block and its surroundings
// assumes 16-bit conversion results and 3-bit channel codes
package acr_pkg;

	typedef enum logic [2:0] {
		ACR_CH_OFF     = 3'b000,
		ACR_CH_AUX     = 3'b001,
		ACR_CH_THERM   = 3'b010,
		ACR_CH_VBAT    = 3'b011,
		ACR_CH_ICHG    = 3'b100,
		ACR_CH_VIN     = 3'b101,
		ACR_CH_SYSRAIL = 3'b110,
		ACR_CH_IIN     = 3'b111
	} acr_chan_t;

	typedef enum logic {
		ACR_CONV_IDLE = 1'b0,
		ACR_CONV_BUSY = 1'b1
	} acr_conv_state_t;

	// one complete conversion set, all channels of one sweep
	typedef struct packed {
		logic [15:0] battery_voltage;
		logic [15:0] thermistor_channel;
		logic [15:0] charge_current;
		logic [15:0] general_purpose_analog_input;
		logic [15:0] input_supply_voltage;
		logic [15:0] system_rail_voltage;
		logic [15:0] input_current;
	} acr_meas_t;

	// threshold and polarity of one comparator, held in registers outside this block
	typedef struct packed {
		logic [15:0] threshold;
		logic        comparator_polarity;
	} acr_cmp_cfg_t;

	typedef struct packed {
		logic       wr_en;
		logic       rd_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} acr_reg_req_t;

endpackage : acr_pkg

// [verilog/acr_core.sv]
// converter control and result block: comparator channel selects, result registers,
// comparator flags for comparators two and three, manual conversion trigger handshake
// assumes the management bus slave presents one register access per cycle on reg_req,
// and the converter pulses conv_done with a full, coherent measurement set
`timescale 1ns/1ps
`include "acr_regs.svh"

module acr_core
	import acr_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire acr_reg_req_t reg_req,
	output logic [7:0]        reg_rdata,
	output logic              reg_rvalid,
	input  wire logic         manual_read_mode,
	input  wire logic         conversion_trigger,
	output logic              conversion_trigger_clear,
	output logic              conv_start,
	input  wire logic         conv_done,
	input  wire acr_meas_t    conv_meas,
	input  wire acr_cmp_cfg_t cmp2_cfg,
	input  wire acr_cmp_cfg_t cmp3_cfg,
	input  wire logic [1:0]   cmp_flag_clear,
	output logic [1:0]        cmp_flag,
	output logic              cmp_irq
);

	logic [7:0]      chan_sel;
	logic [7:0]      next_chan_sel;
	logic [15:0]     vbat_res;
	logic [15:0]     next_vbat_res;
	logic [15:0]     therm_res;
	logic [15:0]     next_therm_res;
	logic [15:0]     ichg_res;
	logic [15:0]     next_ichg_res;
	logic [7:0]      aux_res;
	logic [7:0]      next_aux_res;
	logic [7:0]      next_reg_rdata;
	logic            next_reg_rvalid;
	acr_conv_state_t conv_state;
	acr_conv_state_t next_conv_state;
	logic            next_conv_start;
	logic            next_trigger_clear;
	logic [1:0]      cmp_hit_prev;
	logic [1:0]      next_cmp_hit_prev;
	logic [1:0]      next_cmp_flag;
	logic            next_cmp_irq;
	logic [1:0]      cmp_hit;
	logic            cmp_valid;

	function automatic logic [15:0] chan_value(input logic [2:0] sel, input acr_meas_t m);
		unique case (acr_chan_t'(sel))
			ACR_CH_OFF:     chan_value = 16'h0000;
			ACR_CH_AUX:     chan_value = m.general_purpose_analog_input;
			ACR_CH_THERM:   chan_value = m.thermistor_channel;
			ACR_CH_VBAT:    chan_value = m.battery_voltage;
			ACR_CH_ICHG:    chan_value = m.charge_current;
			ACR_CH_VIN:     chan_value = m.input_supply_voltage;
			ACR_CH_SYSRAIL: chan_value = m.system_rail_voltage;
			ACR_CH_IIN:     chan_value = m.input_current;
		endcase
	endfunction : chan_value

	function automatic logic cmp_test(input logic [2:0] sel, input acr_meas_t m,
		input acr_cmp_cfg_t c);
		logic [15:0] v;
		v = chan_value(sel, m);
		if (sel == 3'b000)
			cmp_test = 1'b0;
		else if (c.comparator_polarity)
			cmp_test = (v > c.threshold);
		else
			cmp_test = (v < c.threshold);
	endfunction : cmp_test

	// register file and readback
	always_comb
	begin
		next_chan_sel   = chan_sel;
		next_vbat_res   = vbat_res;
		next_therm_res  = therm_res;
		next_ichg_res   = ichg_res;
		next_aux_res    = aux_res;
		next_reg_rdata  = reg_rdata;
		next_reg_rvalid = reg_req.rd_en;
		if (reg_req.wr_en)
		begin
			unique case (reg_req.addr)
				`ACR_OFS_CMP_CHAN_SEL: next_chan_sel = reg_req.wdata;
				`ACR_OFS_VBAT_HIGH:    next_vbat_res[15:8] = reg_req.wdata;
				`ACR_OFS_VBAT_LOW:     next_vbat_res[7:0] = reg_req.wdata;
				`ACR_OFS_THERM_HIGH:   next_therm_res[15:8] = reg_req.wdata;
				`ACR_OFS_THERM_LOW:    next_therm_res[7:0] = reg_req.wdata;
				`ACR_OFS_ICHG_HIGH:    next_ichg_res[15:8] = reg_req.wdata;
				`ACR_OFS_ICHG_LOW:     next_ichg_res[7:0] = reg_req.wdata;
				`ACR_OFS_AUX_HIGH:     next_aux_res = reg_req.wdata;
				default:               next_chan_sel = chan_sel;
			endcase
		end
		// a fresh conversion overrides a same-cycle host write so pairs stay coherent
		if (conv_done)
		begin
			next_vbat_res  = conv_meas.battery_voltage;
			next_therm_res = conv_meas.thermistor_channel;
			next_ichg_res  = conv_meas.charge_current;
			next_aux_res   = conv_meas.general_purpose_analog_input[15:8];
		end
		if (reg_req.rd_en)
		begin
			unique case (reg_req.addr)
				`ACR_OFS_CMP_CHAN_SEL: next_reg_rdata = chan_sel;
				`ACR_OFS_VBAT_HIGH:    next_reg_rdata = vbat_res[15:8];
				`ACR_OFS_VBAT_LOW:     next_reg_rdata = vbat_res[7:0];
				`ACR_OFS_THERM_HIGH:   next_reg_rdata = therm_res[15:8];
				`ACR_OFS_THERM_LOW:    next_reg_rdata = therm_res[7:0];
				`ACR_OFS_ICHG_HIGH:    next_reg_rdata = ichg_res[15:8];
				`ACR_OFS_ICHG_LOW:     next_reg_rdata = ichg_res[7:0];
				`ACR_OFS_AUX_HIGH:     next_reg_rdata = aux_res;
				default:               next_reg_rdata = `ACR_UNMAPPED_READ;
			endcase
		end
	end

	// results carry no reset: their content is undefined until the first conversion or host write
	always_ff @(posedge clk)
	begin
		vbat_res  <= next_vbat_res;
		therm_res <= next_therm_res;
		ichg_res  <= next_ichg_res;
		aux_res   <= next_aux_res;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			chan_sel   <= `ACR_RST_CMP_CHAN_SEL;
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			chan_sel   <= next_chan_sel;
			reg_rdata  <= next_reg_rdata;
			reg_rvalid <= next_reg_rvalid;
		end
	end

	// manual conversion handshake
	always_comb
	begin
		next_conv_state    = conv_state;
		next_conv_start    = 1'b0;
		next_trigger_clear = 1'b0;
		unique case (conv_state)
			ACR_CONV_IDLE:
				// the clear pulse blocks a restart while the trigger bit is still falling
				if (manual_read_mode && conversion_trigger && !conversion_trigger_clear)
				begin
					next_conv_state = ACR_CONV_BUSY;
					next_conv_start = 1'b1;
				end
			ACR_CONV_BUSY:
				if (conv_done)
				begin
					next_conv_state    = ACR_CONV_IDLE;
					next_trigger_clear = 1'b1;
				end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			conv_state               <= ACR_CONV_IDLE;
			conv_start               <= 1'b0;
			conversion_trigger_clear <= 1'b0;
		end
		else
		begin
			conv_state               <= next_conv_state;
			conv_start               <= next_conv_start;
			conversion_trigger_clear <= next_trigger_clear;
		end
	end

	// comparators act on the crossing, not on every conversion past the threshold
	assign cmp_valid  = conv_done;
	assign cmp_hit[0] = cmp_test(chan_sel[`ACR_CMP2_MSB:`ACR_CMP2_LSB], conv_meas, cmp2_cfg);
	assign cmp_hit[1] = cmp_test(chan_sel[`ACR_CMP3_MSB:`ACR_CMP3_LSB], conv_meas, cmp3_cfg);

	always_comb
	begin
		next_cmp_hit_prev = cmp_hit_prev;
		next_cmp_flag     = cmp_flag & ~cmp_flag_clear;
		next_cmp_irq      = 1'b0;
		if (cmp_valid)
		begin
			next_cmp_hit_prev = cmp_hit;
			// set beats a same-cycle clear
			next_cmp_flag = next_cmp_flag | (cmp_hit & ~cmp_hit_prev);
			next_cmp_irq  = |(cmp_hit & ~cmp_hit_prev);
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cmp_hit_prev <= 2'b00;
			cmp_flag     <= 2'b00;
			cmp_irq      <= 1'b0;
		end
		else
		begin
			cmp_hit_prev <= next_cmp_hit_prev;
			cmp_flag     <= next_cmp_flag;
			cmp_irq      <= next_cmp_irq;
		end
	end

endmodule : acr_core

// [dv/acr_core_assertions.sv]
// port checker for the converter control and result block
// assumes one clock and synchronous active-high reset
`timescale 1ns/1ps
module acr_core_assertions
	import acr_pkg::*;
(
	input wire logic         clk,
	input wire logic         rst,
	input wire acr_reg_req_t reg_req,
	input wire logic [7:0]   reg_rdata,
	input wire logic         reg_rvalid,
	input wire logic         manual_read_mode,
	input wire logic         conversion_trigger,
	input wire logic         conversion_trigger_clear,
	input wire logic         conv_start,
	input wire logic         conv_done,
	input wire logic [1:0]   cmp_flag,
	input wire logic         cmp_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_rd; reg_req.rd_en |=> reg_rvalid; endproperty
	a_rd: assert property (p_rd) else $error("read not answered");
	property p_rstv;
		$fell(rst) && reg_req.rd_en && !reg_req.wr_en && reg_req.addr == 8'h41
			|=> reg_rdata == 8'h40;
	endproperty
	a_rstv: assert property (p_rstv) else $error("select reset value");
	property p_st; conv_start |-> $past(manual_read_mode) && $past(conversion_trigger); endproperty
	a_st: assert property (p_st) else $error("start without trigger");
	property p_stp; conv_start |=> !conv_start; endproperty
	a_stp: assert property (p_stp) else $error("start too long");
	property p_clr; conversion_trigger_clear |-> $past(conv_done); endproperty
	a_clr: assert property (p_clr) else $error("clear without done");
	property p_clp; conversion_trigger_clear |=> !conversion_trigger_clear; endproperty
	a_clp: assert property (p_clp) else $error("clear too long");
	property p_irq; cmp_irq |-> $past(conv_done) && cmp_flag != 2'b00; endproperty
	a_irq: assert property (p_irq) else $error("stray interrupt");
	property p_fr; (cmp_flag & ~$past(cmp_flag)) != 2'b00 |-> $past(conv_done); endproperty
	a_fr: assert property (p_fr) else $error("flag without conversion");
	c_irq: cover property (cmp_irq);
	c_clr: cover property (conversion_trigger_clear);
	c_rd: cover property (reg_rvalid);
endmodule : acr_core_assertions
bind acr_core acr_core_assertions u_chk (.clk, .rst, .reg_req, .reg_rdata, .reg_rvalid,
	.manual_read_mode, .conversion_trigger, .conversion_trigger_clear, .conv_start,
	.conv_done, .cmp_flag, .cmp_irq);

// [dv/acr_conv_model.sv]
// converter model: answers each start with one measurement set
// assumes one-cycle conv_start; slow picks a long conversion
`timescale 1ns/1ps
module acr_conv_model
	import acr_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic conv_start,
	input  wire logic slow,
	output logic      conv_done,
	output acr_meas_t conv_meas
);
	int           cnt;
	logic [127:0] r;
	always @(posedge clk)
	begin
		r = {$urandom, $urandom, $urandom, $urandom};
		conv_done <= 1'b0;
		// results only hold with conv_done, so they churn otherwise
		conv_meas <= rst ? r[111:0] : ~conv_meas;
		if (rst)
			cnt <= 0;
		else if (conv_start)
			cnt <= slow ? 40 : 1;
		else if (cnt == 1)
		begin
			conv_done <= 1'b1;
			conv_meas <= r[111:0];
			cnt       <= 0;
		end
		else if (cnt > 1)
			cnt <= cnt - 1;
	end
endmodule : acr_conv_model

// [dv/tb_top.sv]
// self-checking bench for the converter control and result block
// assumes the converter model stands behind conv_start and conv_done
`timescale 1ns/1ps
module tb_top;
	import acr_pkg::*;
	logic         clk = 1'b0;
	logic         rst = 1'b1;
	acr_reg_req_t reg_req = '0;
	logic [7:0]   reg_rdata;
	logic         reg_rvalid;
	logic         manual_read_mode = 1'b1;
	logic         conversion_trigger = 1'b0;
	logic         conversion_trigger_clear;
	logic         conv_start;
	logic         conv_done;
	acr_meas_t    conv_meas;
	acr_cmp_cfg_t cmp2_cfg = '0;
	acr_cmp_cfg_t cmp3_cfg = '0;
	logic [1:0]   cmp_flag_clear = '0;
	logic [1:0]   cmp_flag;
	logic         cmp_irq;
	logic         slow = 1'b0;
	int           n_errors = 0;
	int           num_checks = 0;
	int           n_starts = 0;
	int           k;
	int           it;
	int           fi[8] = '{0, 3, 1, 0, 2, 4, 5, 6};
	logic         prev[2] = '{1'b0, 1'b0};
	logic [2:0]   sel[2];
	logic [31:0]  s;
	logic [15:0]  v;
	logic [15:0]  t;
	logic         hit;
	logic [1:0]   ef;
	acr_meas_t    m;
	always #5 clk = ~clk;
	// every start the converter gets is counted; a restart or a start in non-manual mode shows up as an extra start
	always @(negedge clk)
		if (conv_start === 1'b1)
			n_starts++;
	acr_core uut (.clk, .rst, .reg_req, .reg_rdata, .reg_rvalid, .manual_read_mode,
		.conversion_trigger, .conversion_trigger_clear, .conv_start, .conv_done, .conv_meas,
		.cmp2_cfg, .cmp3_cfg, .cmp_flag_clear, .cmp_flag, .cmp_irq);
	acr_conv_model u_conv (.clk, .rst, .conv_start, .slow, .conv_done, .conv_meas);
	task chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s exp %h seen %h", n, exp, seen);
		end
	endtask : chk
	task tally_and_finish;
		if (n_errors == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	task wr(input logic [7:0] a, input logic [7:0] d);
		reg_req <= '{1'b1, 1'b0, a, d};
		@(negedge clk);
		reg_req <= '0;
		@(negedge clk);
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		reg_req <= '{1'b0, 1'b1, a, 8'h00};
		@(negedge clk);
		reg_req <= '0;
		chk("rvalid", reg_rvalid, 1'b1);
		chk("rdata", reg_rdata, e);
		@(negedge clk);
	endtask : rd
	initial
	begin
		void'($urandom(32'hB219));
		repeat (8) @(negedge clk);
		rst <= 1'b0;
		rd(8'h41, 8'h40);
		wr(8'h41, 8'hA7);
		rd(8'h41, 8'hA7);
		wr(8'h42, 8'h5C);
		rd(8'h42, 8'h5C);
		rd(8'h49, 8'h00);
		for (it = 0; it < 16; it++)
		begin
			s = $urandom;
			sel[0] = s[7:5];
			sel[1] = s[4:2];
			cmp2_cfg <= '{s[31:16], s[8]};
			cmp3_cfg <= '{~s[31:16], s[9]};
			slow <= it[0];
			// trigger while not in manual mode must be ignored
			manual_read_mode <= 1'b0;
			conversion_trigger <= 1'b1;
			cmp_flag_clear <= 2'b11;
			wr(8'h41, s[7:0]);
			cmp_flag_clear <= 2'b00;
			manual_read_mode <= 1'b1;
			chk("flagclr", cmp_flag, 2'b00);
			for (k = 0; k < 90 && conv_done !== 1'b1; k++)
				@(negedge clk);
			if (conv_done !== 1'b1)
			begin
				n_errors++;
				tally_and_finish();
			end
			m = conv_meas;
			@(negedge clk);
			conversion_trigger <= 1'b0;
			chk("trigclr", conversion_trigger_clear, 1'b1);
			for (k = 0; k < 2; k++)
			begin
				v = m[111 - 16 * fi[sel[k]] -: 16];
				t = k ? ~s[31:16] : s[31:16];
				hit = sel[k] != 3'h0 && (s[8 + k] ? v > t : v < t);
				ef[k] = hit && !prev[k];
				prev[k] = hit;
			end
			chk("flag", cmp_flag, ef);
			chk("irq", cmp_irq, |ef);
			for (k = 0; k < 7; k++)
				rd(8'(8'h42 + k), m[111 - 8 * k -: 8]);
			chk("starts", 16'(n_starts), 16'(it + 1));
		end
		tally_and_finish();
	end
endmodule : tb_top
